// ---- hdl/pbs_cfg.svh ----
// Constants of the configuration status register block.
// Assumes inclusion by the package, the design modules, the checker and the bench.
`ifndef PBS_CFG_SVH
`define PBS_CFG_SVH

// ****************************************
// Offsets and reset values
// ****************************************
`define PBS_STATUS_OFFSET 8'h06
`define PBS_COMMAND_OFFSET 8'h04
`define PBS_STATUS_RESET 16'h0210
`define PBS_COMMAND_RESET 16'h0000

// ****************************************
// Status fields
// ****************************************
`define PBS_BIT_PARITY_DETECTED 15
`define PBS_BIT_SYSERR_SIGNALED 14
`define PBS_BIT_MASTER_ABORT_RECEIVED_RECEIVED 13
`define PBS_BIT_TABORT_RECEIVED 12
`define PBS_BIT_TABORT_SIGNALED 11
`define PBS_BIT_DATA_PARITY 8
`define PBS_DEVSEL_TIMING 2'h1
`define PBS_CAPABILITY_LIST_PRESENT_VALUE 1'h1
`define PBS_FIXED_ZERO 1'h0
`define PBS_RESERVED_VALUE 4'h0

// ****************************************
// Command fields
// ****************************************
`define PBS_BIT_SYSERR_ENABLE 8
`define PBS_BIT_PARITY_ENABLE 6
`define PBS_COMMAND_RW_MASK 16'h0167

// ****************************************
// Function count
// ****************************************
`define PBS_NUM_FUNCTIONS 2

`endif

// ---- hdl/pbs_pkg.sv ----
// Types shared by the configuration status register block.
// Assumes pbs_cfg.svh is on the include path.
`include "pbs_cfg.svh"

package pbs_pkg;
    // Clearable flags of one function, in status bit order 15..11, 8
    typedef struct packed {
        logic parity_error_detected;
        logic system_error_signaled;
        logic master_abort_received;
        logic target_abort_received;
        logic target_abort_signaled;
        logic master_data_parity_error;
    } pbs_flags_t;

    typedef enum logic [1:0] {
        PBS_ACC_NONE,
        PBS_ACC_STATUS,
        PBS_ACC_COMMAND,
        PBS_ACC_OTHER
    } pbs_access_t;
endpackage

// ---- hdl/pbs_status_flags.sv ----
// One function's clearable status flags with write-one-to-clear.
// Assumes the event inputs are one-cycle pulses on ref_clk.
`timescale 1ns/10ps
`default_nettype none
`include "pbs_cfg.svh"

module pbs_status_flags (
    input wire logic ref_clk,
    input wire logic reset,
    input wire pbs_pkg::pbs_flags_t set_ev,
    input wire pbs_pkg::pbs_flags_t clear_ev,
    output pbs_pkg::pbs_flags_t flags_q
);
    pbs_pkg::pbs_flags_t flags_d;

    // Set wins over clear so no event is lost
    always_comb begin
        flags_d = (flags_q & ~clear_ev) | set_ev; // R1 R18
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            flags_q <= '0; // R19
        end else begin
            flags_q <= flags_d;
        end
    end
endmodule
`default_nettype wire

// ---- hdl/pbs_config_status.sv ----
// Status register, with its two error enables, for both functions.
// Assumes the PCI interface logic gives one-cycle event pulses and a
// one-cycle configuration access strobe, all on ref_clk.
//
// What this block does
// R1: Writing 1 clears a flag, 0 leaves it; reads have no side effects.
// R2: Status sits at offset 06h in both functions, resets to 0210h.
// R3: Bit 15 sets on any address or data parity error detected.
// R4: Bit 14 sets when system error is signalled, with the enables wired-OR across both functions.
// R5: Bit 13 sets when our initiated cycle ends in master abort.
// R6: Bit 12 sets when our initiated cycle receives a target abort.
// R7: Bit 11 sets when we end a cycle as target with target abort.
// R8: Bits 10..9 are fixed 01b, medium decode timing.
// R9: Bit 8 sets on data parity error as master, error seen, enabled.
// R10: Bit 7 reads 0, no fast back-to-back acceptance.
// R11: Bit 6 reads 0, no user-definable features.
// R12: Bit 5 reads 0, not high-speed capable.
// R13: Bit 4 reads 1, capability list present.
// R14: Bits 3..0 read zero.
// R15: Each function has its own status register instance.
// R16: Parity response enable gates all parity error response.
// R17: Address parity on system error only with both enables set, each taken from either function.
// R18: Simultaneous set and clear leaves the flag set.
// R19: Reset clears flags; fixed fields never change.
`timescale 1ns/10ps
`default_nettype none
`include "pbs_cfg.svh"

module pbs_config_status (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic cfg_valid,
    input wire logic cfg_func,
    input wire logic cfg_write,
    input wire logic [7:0] cfg_offset,
    input wire logic [15:0] cfg_wdata,
    input wire logic [1:0] cfg_byte_en,
    output logic [15:0] cfg_rdata_q,
    output logic cfg_hit_q,
    input wire logic [1:0] addr_parity_error,
    input wire logic [1:0] data_parity_error,
    input wire logic [1:0] parity_error_seen,
    input wire logic [1:0] was_bus_master,
    input wire logic [1:0] master_abort,
    input wire logic [1:0] target_abort_rx,
    input wire logic [1:0] target_abort_tx,
    output logic [1:0] parity_response_enable,
    output logic [1:0] system_error_enable,
    output logic perr_assert,
    output logic serr_assert
);
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [15:0] status_word(
        input pbs_pkg::pbs_flags_t f
    );
        status_word = {f.parity_error_detected, f.system_error_signaled,
            f.master_abort_received, f.target_abort_received,
            f.target_abort_signaled,
            `PBS_DEVSEL_TIMING, // R8
            f.master_data_parity_error,
            `PBS_FIXED_ZERO, // R10
            `PBS_FIXED_ZERO, // R11
            `PBS_FIXED_ZERO, // R12
            `PBS_CAPABILITY_LIST_PRESENT_VALUE, // R13
            `PBS_RESERVED_VALUE}; // R14 R19
    endfunction

    function automatic pbs_pkg::pbs_flags_t w1c_mask(
        input logic [15:0] d
    );
        w1c_mask.parity_error_detected = d[`PBS_BIT_PARITY_DETECTED];
        w1c_mask.system_error_signaled = d[`PBS_BIT_SYSERR_SIGNALED];
        w1c_mask.master_abort_received = d[`PBS_BIT_MASTER_ABORT_RECEIVED_RECEIVED];
        w1c_mask.target_abort_received = d[`PBS_BIT_TABORT_RECEIVED];
        w1c_mask.target_abort_signaled = d[`PBS_BIT_TABORT_SIGNALED];
        w1c_mask.master_data_parity_error = d[`PBS_BIT_DATA_PARITY];
    endfunction

    // ****************************************
    // Access decode
    // ****************************************
    pbs_pkg::pbs_access_t acc;
    logic [15:0] wmask;

    always_comb begin
        if (!cfg_valid) begin
            acc = pbs_pkg::PBS_ACC_NONE;
        end else if (cfg_offset == `PBS_STATUS_OFFSET) begin
            acc = pbs_pkg::PBS_ACC_STATUS; // R2
        end else if (cfg_offset == `PBS_COMMAND_OFFSET) begin
            acc = pbs_pkg::PBS_ACC_COMMAND;
        end else begin
            acc = pbs_pkg::PBS_ACC_OTHER;
        end
        wmask = {{8{cfg_byte_en[1]}}, {8{cfg_byte_en[0]}}} & cfg_wdata;
    end

    // ****************************************
    // Command registers, one per function
    // ****************************************
    logic [15:0] cmd_q [`PBS_NUM_FUNCTIONS];
    pbs_pkg::pbs_flags_t flags_q [`PBS_NUM_FUNCTIONS];

    function automatic logic [15:0] wide_be();
        wide_be = {{8{cfg_byte_en[1]}}, {8{cfg_byte_en[0]}}} &
            `PBS_COMMAND_RW_MASK;
    endfunction

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cmd_q[0] <= `PBS_COMMAND_RESET;
            cmd_q[1] <= `PBS_COMMAND_RESET;
        end else if (acc == pbs_pkg::PBS_ACC_COMMAND && cfg_write) begin
            cmd_q[cfg_func] <= (cmd_q[cfg_func] & ~wide_be()) |
                (wmask & `PBS_COMMAND_RW_MASK);
        end
    end

    // ****************************************
    // Per-function flags
    // ****************************************
    // Enables are wired-OR across functions for error reporting
    logic parity_response_enable_any;
    logic system_error_enable_any;
    logic [1:0] serr_fire;

    always_comb begin
        parity_response_enable[0] = cmd_q[0][`PBS_BIT_PARITY_ENABLE];
        parity_response_enable[1] = cmd_q[1][`PBS_BIT_PARITY_ENABLE];
        system_error_enable[0] = cmd_q[0][`PBS_BIT_SYSERR_ENABLE];
        system_error_enable[1] = cmd_q[1][`PBS_BIT_SYSERR_ENABLE];
        parity_response_enable_any = |parity_response_enable;
        system_error_enable_any = |system_error_enable;
        serr_fire = addr_parity_error & {2{parity_response_enable_any & system_error_enable_any}}; // R17
        perr_assert = |data_parity_error & parity_response_enable_any; // R16
        serr_assert = |serr_fire; // R4
    end

    for (genvar i = 0; i < `PBS_NUM_FUNCTIONS; i++) begin : g_fn
        pbs_pkg::pbs_flags_t set_ev;
        pbs_pkg::pbs_flags_t clr_ev;

        always_comb begin
            set_ev.parity_error_detected =
                addr_parity_error[i] | data_parity_error[i]; // R3
            set_ev.system_error_signaled = serr_fire[i]; // R4
            set_ev.master_abort_received = master_abort[i]; // R5
            set_ev.target_abort_received = target_abort_rx[i]; // R6
            set_ev.target_abort_signaled = target_abort_tx[i]; // R7
            set_ev.master_data_parity_error = parity_error_seen[i] &
                was_bus_master[i] & parity_response_enable[i]; // R9 R16
            if (acc == pbs_pkg::PBS_ACC_STATUS && cfg_write &&
                    cfg_func == 1'(i)) begin
                clr_ev = w1c_mask(wmask); // R1
            end else begin
                clr_ev = '0;
            end
        end

        pbs_status_flags u_flags ( // R15
            .ref_clk(ref_clk),
            .reset(reset),
            .set_ev(set_ev),
            .clear_ev(clr_ev),
            .flags_q(flags_q[i])
        );
    end

    // ****************************************
    // Read path
    // ****************************************
    // Reads only sample; no read-clear so polling is harmless
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cfg_rdata_q <= 16'h0000;
        end else if (acc == pbs_pkg::PBS_ACC_STATUS && !cfg_write) begin
            cfg_rdata_q <= status_word(flags_q[cfg_func]); // R1 R2
        end else if (acc == pbs_pkg::PBS_ACC_COMMAND && !cfg_write) begin
            cfg_rdata_q <= cmd_q[cfg_func];
        end else if (cfg_valid && !cfg_write) begin
            cfg_rdata_q <= 16'h0000;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cfg_hit_q <= 1'b0;
        end else begin
            cfg_hit_q <= acc == pbs_pkg::PBS_ACC_STATUS ||
                acc == pbs_pkg::PBS_ACC_COMMAND;
        end
    end
endmodule
`default_nettype wire

// ---- verif/pbs_bus_agent.sv ----
// Far-side bus agent: held event requests become one-cycle pulses.
// Assumes requests change just after a rising ref_clk edge.
`timescale 1ns/10ps
`default_nettype none
module pbs_bus_agent (
    input wire logic ref_clk,
    input wire logic [11:0] ev_req,
    output logic [11:0] ev_pulse
);
    logic [11:0] ev_q;
    // Edge detect, so a request held too long still pulses once
    always_ff @(posedge ref_clk) begin
        ev_q <= ev_req;
    end
    assign ev_pulse = ev_req & ~ev_q;
endmodule
`default_nettype wire

// ---- verif/pbs_config_status_sva.sv ----
// Port checker of the status register block.
// Assumes it is bound onto pbs_config_status.
`timescale 1ns/10ps
`default_nettype none
`include "pbs_cfg.svh"
module pbs_status_sva (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic cfg_valid,
    input wire logic cfg_write,
    input wire logic [7:0] cfg_offset,
    input wire logic [15:0] cfg_rdata_q,
    input wire logic cfg_hit_q,
    input wire logic [1:0] addr_parity_error,
    input wire logic [1:0] data_parity_error,
    input wire logic [1:0] parity_response_enable,
    input wire logic [1:0] system_error_enable,
    input wire logic perr_assert,
    input wire logic serr_assert
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    wire logic rd = cfg_valid && !cfg_write;
    wire logic mapped = cfg_offset == `PBS_STATUS_OFFSET ||
        cfg_offset == `PBS_COMMAND_OFFSET;
    a_hit_mapped: assert property (cfg_valid && mapped |=> cfg_hit_q)
        else $error("no hit after mapped access");
    a_miss_quiet: assert property (rd && !mapped |=>
        !cfg_hit_q && cfg_rdata_q == 16'h0) else $error("unmapped read");
    a_fixed_fields: assert property (rd && cfg_offset == `PBS_STATUS_OFFSET
        |=> cfg_rdata_q[10:9] == 2'h1 && cfg_rdata_q[7:0] == 8'h10)
        else $error("fixed status fields wrong");
    a_hit_pulse: assert property (!cfg_valid |=> !cfg_hit_q)
        else $error("hit without access");
    a_rdata_hold: assert property (!rd |=> $stable(cfg_rdata_q))
        else $error("read data changed without read");
    a_perr_gate: assert property (perr_assert ==
        (|data_parity_error && |parity_response_enable))
        else $error("parity output gating wrong");
    a_serr_gate: assert property (serr_assert == (|addr_parity_error &&
        |parity_response_enable && |system_error_enable))
        else $error("system error gating wrong");
    a_reset_clear: assert property ($past(reset) |-> !cfg_hit_q &&
        cfg_rdata_q == 16'h0 && parity_response_enable == 2'h0 &&
        system_error_enable == 2'h0) else $error("state after reset");
endmodule
bind pbs_config_status pbs_status_sva chk (.*);
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench of the status register block.
// Assumes design, agent and checker files are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "pbs_cfg.svh"
module tb_top;
    logic ref_clk, reset, cfg_valid, cfg_func, cfg_write, cfg_hit_q;
    logic perr_assert, serr_assert, rd_pend;
    logic [7:0] cfg_offset;
    logic [15:0] cfg_wdata, cfg_rdata_q, r;
    logic [1:0] cfg_byte_en, was_bus_master, pre, see;
    logic [11:0] ev_req, ev;
    logic [15:0] expq[$];
    int num_errors = 0;
    int samples_checked = 0;
    pbs_bus_agent agent (.ref_clk, .ev_req, .ev_pulse(ev));
    pbs_config_status uut (.ref_clk, .reset, .cfg_valid, .cfg_func,
        .cfg_write, .cfg_offset, .cfg_wdata, .cfg_byte_en, .cfg_rdata_q,
        .cfg_hit_q, .addr_parity_error(ev[11:10]),
        .data_parity_error(ev[9:8]), .parity_error_seen(ev[7:6]),
        .was_bus_master, .master_abort(ev[5:4]),
        .target_abort_rx(ev[3:2]), .target_abort_tx(ev[1:0]),
        .parity_response_enable(pre), .system_error_enable(see),
        .perr_assert, .serr_assert);
    task automatic check(input string n, input logic [15:0] s, e);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic acc(input logic f, w, input logic [7:0] o,
                       input logic [15:0] d, input logic [1:0] be);
        {cfg_valid, cfg_func, cfg_write} = {1'h1, f, w};
        {cfg_offset, cfg_wdata, cfg_byte_en} = {o, d, be};
        @(posedge ref_clk) #1;
    endtask
    task automatic rd(input logic f, input logic [7:0] o, logic [15:0] e);
        expq.push_back(e);
        acc(f, 1'h0, o, 16'h0, 2'h3);
    endtask
    task automatic idle();
        cfg_valid = 1'h0;
        @(posedge ref_clk) #1;
    endtask
    task automatic fire(input logic [11:0] e, input logic [1:0] pe);
        ev_req = e;
        cfg_valid = 1'h0;
        #1 check("perr serr", {14'h0, perr_assert, serr_assert}, {14'h0, pe});
        @(posedge ref_clk) #1;
        ev_req = 12'h0;
    endtask
    task automatic complete_run();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Read data is due on the same edge that takes the read
    always @(posedge ref_clk) begin
        #2;
        if (rd_pend && expq.size() > 0)
            check("rdata", cfg_rdata_q, expq.pop_front());
        rd_pend = cfg_valid && !cfg_write;
    end
    initial begin
        ref_clk = 1'h0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial begin
        #5000;
        num_errors++;
        complete_run();
    end
    initial begin
        {reset, rd_pend, cfg_valid, cfg_func, cfg_write} = 5'h10;
        {cfg_offset, cfg_wdata, cfg_byte_en, ev_req, was_bus_master} = '0;
        r = 16'($urandom(32'he294));
        repeat (2) @(posedge ref_clk);
        #1 reset = 1'h0;
        for (int f = 0; f < 2; f++) begin
            acc(f[0], 1'h1, `PBS_STATUS_OFFSET, 16'hffff, 2'h3);
            acc(f[0], 1'h1, 8'h08, 16'hffff, 2'h3);
            rd(f[0], `PBS_STATUS_OFFSET, `PBS_STATUS_RESET);
            rd(f[0], 8'h08, 16'h0);
            r = 16'($urandom());
            acc(f[0], 1'h1, `PBS_COMMAND_OFFSET, r, 2'h1);
            rd(f[0], `PBS_COMMAND_OFFSET, r & 16'h0067);
        end
        acc(1'h0, 1'h1, `PBS_COMMAND_OFFSET, 16'h0140, 2'h3);
        acc(1'h1, 1'h1, `PBS_COMMAND_OFFSET, 16'h0000, 2'h3);
        check("enables", {12'h0, see, pre}, 16'h0005);
        was_bus_master = 2'h1;
        fire(12'hfff, 2'h3);
        was_bus_master = 2'h0;
        rd(1'h0, `PBS_STATUS_OFFSET, 16'hfb10);
        rd(1'h1, `PBS_STATUS_OFFSET, 16'hfa10);
        acc(1'h0, 1'h1, `PBS_STATUS_OFFSET, 16'h8000, 2'h3);
        acc(1'h0, 1'h1, `PBS_STATUS_OFFSET, 16'h0000, 2'h3);
        acc(1'h0, 1'h1, `PBS_STATUS_OFFSET, 16'h4000, 2'h1);
        rd(1'h0, `PBS_STATUS_OFFSET, 16'h7b10);
        ev_req = 12'h010;
        acc(1'h0, 1'h1, `PBS_STATUS_OFFSET, 16'h2000, 2'h3);
        ev_req = 12'h0;
        rd(1'h0, `PBS_STATUS_OFFSET, 16'h7b10);
        acc(1'h1, 1'h1, `PBS_STATUS_OFFSET, 16'hffff, 2'h3);
        rd(1'h1, `PBS_STATUS_OFFSET, `PBS_STATUS_RESET);
        // Mid-run reset, then address parity with only bit 6 enabled
        reset = 1'h1;
        idle();
        reset = 1'h0;
        acc(1'h0, 1'h1, `PBS_COMMAND_OFFSET, 16'h0040, 2'h3);
        check("enables", {12'h0, see, pre}, 16'h0001);
        fire(12'h400, 2'h0);
        rd(1'h0, `PBS_STATUS_OFFSET, 16'h8210);
        idle();
        repeat (2) @(posedge ref_clk);
        complete_run();
    end
endmodule
`default_nettype wire
